// ===== logic/smbt_defs.svh
// constants for the bus target command decoder
// assumes inclusion by bare name from package and design
`ifndef SMBT_DEFS_SVH
`define SMBT_DEFS_SVH
`define SMBT_ADDR_RESET     7'h44
`define SMBT_REG_CMD        8'h00
`define SMBT_REG_CAP        8'h00
`define SMBT_REG_PSTATE     8'h01
`define SMBT_CMD_WAKE       8'h01
`define SMBT_CMD_PWRDN      8'h02
`define SMBT_CMD_RST_WARM   8'h03
`define SMBT_CMD_RST_COLD   8'h04
`define SMBT_CMD_MSG_OFF    8'h05
`define SMBT_CMD_WATCHDOG_RELOAD_COMMAND  8'h06
`define SMBT_CMD_LINK_INT   8'h08
`define SMBT_CAP_VALUE      8'h00
`define SMBT_PS_S0          3'h0
`define SMBT_PS_S3          3'h3
`define SMBT_PS_S4          3'h4
`define SMBT_PS_S5          3'h5
`define SMBT_PS_LSB         0
`define SMBT_PS_MSB         2
`endif

// ===== logic/smbt_pkg.sv
// types for the bus target command decoder
// assumes smbt_defs.svh is on the include path
`include "smbt_defs.svh"
package smbt_pkg;
  typedef enum logic [2:0] {
    SMBT_IDLE,
    SMBT_ADDR,
    SMBT_ACK,
    SMBT_RX,
    SMBT_TX,
    SMBT_TXACK,
    SMBT_IGNORE
  } smbt_state_e;
  typedef logic [2:0] smbt_pstate_t;
endpackage

// ===== logic/smbt_target.sv
// bus target command decoder: byte write commands and byte read status
// assumes scl/sda come from pins on a slow clock; system state from the
// power controller on core_clk_in; pulses go to system logic
`timescale 1ns/100ps
`include "smbt_defs.svh"
module smbt_target
(
  input  wire logic                  core_clk_in,
  input  wire logic                  rst_b_in,
  input  wire logic                  resume_well_reset_n_in,
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  input  wire logic [6:0]            receive_target_address_in,
  input  wire logic                  system_awake_in,
  input  wire smbt_pkg::smbt_pstate_t power_state_in,
  input  wire logic                  me_m3_in,
  input  wire logic                  graceful_sleep_in,
  input  wire logic                  bus_wake_status_clr_in,
  input  wire logic                  power_button_override_status_clr_in,
  input  wire logic                  link_target_interrupt_status_clr_in,
  output logic                       sda_out,
  output logic                       sda_oe_out,
  output logic                       wake_out,
  output logic                       system_management_interrupt_out,
  output logic                       power_down_out,
  output logic                       reset_warm_out,
  output logic                       reset_cold_out,
  output logic                       watchdog_reload_command_out,
  output logic                       health_monitor_msg_en_out,
  output logic                       bus_wake_status_out,
  output logic                       power_button_override_status_out,
  output logic                       link_target_interrupt_status_out,
  output logic                       link_target_interrupt_out
);
  import smbt_pkg::*;

  // pin synchronisers; first stage read only by second
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       scl_d;
  logic       sda_d;
  logic [1:0] rsm_sync;
  logic       rsm_d;

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      scl_sync <= 2'h3;
      scl_d    <= 1'b1;
    end
    else
    begin
      scl_sync <= {scl_sync[0], scl_in};
      scl_d    <= scl_sync[1];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sda_sync <= 2'h3;
      sda_d    <= 1'b1;
    end
    else
    begin
      sda_sync <= {sda_sync[0], sda_in};
      sda_d    <= sda_sync[1];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rsm_sync <= 2'h0;
      rsm_d    <= 1'b0;
    end
    else
    begin
      rsm_sync <= {rsm_sync[0], resume_well_reset_n_in};
      rsm_d    <= rsm_sync[1];
    end
  end

  wire scl_s     = scl_sync[1];
  wire sda_s     = sda_sync[1];
  wire scl_rise  = scl_s & ~scl_d;
  wire scl_fall  = ~scl_s & scl_d;
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det  = scl_s & scl_d & ~sda_d & sda_s;
  wire rsm_rise  = rsm_s_rise();

  function automatic logic rsm_s_rise();
    rsm_s_rise = rsm_sync[1] & ~rsm_d;
  endfunction

  function automatic logic [7:0] read_mux(input logic [7:0] idx,
                                          input smbt_pstate_t ps);
    if (idx == `SMBT_REG_CAP)
      read_mux = `SMBT_CAP_VALUE;
    else if (idx == `SMBT_REG_PSTATE)
      read_mux = {5'h00, ps};
    else
      read_mux = 8'h00;
  endfunction

  smbt_state_e state;
  smbt_state_e next_state;
  logic [7:0]  shift;
  logic [3:0]  bitcnt;
  logic [1:0]  byte_idx;
  logic        read_phase;
  logic [7:0]  reg_sel;
  logic [7:0]  tx_byte;

  wire byte_done = (bitcnt == 4'h8);
  // last read bit: the next fall must release sda for the not-ack slot
  wire tx_last   = (bitcnt == 4'h7);
  wire addr_hit  = (shift[7:1] == receive_target_address_in);
  wire in_s0     = (power_state_in == `SMBT_PS_S0);

  // write completes when data byte (third) is received with reg 0 selected
  wire cmd_fire  = (state == SMBT_ACK) && scl_fall && !read_phase &&
                   (byte_idx == 2'h3) && (reg_sel == `SMBT_REG_CMD);
  wire [7:0] cmd = shift;

  always_comb
  begin
    next_state = state;
    case (state)
      SMBT_IDLE:   next_state = SMBT_IDLE;
      SMBT_ADDR:
        if (scl_fall && byte_done)
          next_state = addr_hit ? SMBT_ACK : SMBT_IGNORE;
      SMBT_RX:
        if (scl_fall && byte_done)
          next_state = SMBT_ACK;
      SMBT_ACK:
        if (scl_fall)
          next_state = read_phase ? SMBT_TX : SMBT_RX;
      SMBT_TX:
        if (scl_fall && tx_last)
          next_state = SMBT_TXACK;
      SMBT_TXACK:
        if (scl_rise)
          next_state = SMBT_IGNORE; // nack expected; single byte read
      SMBT_IGNORE: next_state = SMBT_IGNORE;
      default:     next_state = SMBT_IDLE;
    endcase
    if (start_det)
      next_state = SMBT_ADDR;
    else if (stop_det)
      next_state = SMBT_IDLE;
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state      <= SMBT_IDLE;
      shift      <= 8'h00;
      bitcnt     <= 4'h0;
      byte_idx   <= 2'h0;
      read_phase <= 1'b0;
      reg_sel    <= 8'h00;
      tx_byte    <= 8'h00;
    end
    else
    begin
      state <= next_state;
      if (start_det)
      begin
        bitcnt     <= 4'h0;
        // repeated start after a command byte turns into the read phase
        read_phase <= (byte_idx == 2'h2) && (state == SMBT_RX);
        if (state == SMBT_IDLE || state == SMBT_IGNORE)
          byte_idx <= 2'h0;
      end
      else if (scl_rise && (state == SMBT_ADDR || state == SMBT_RX))
      begin
        shift  <= {shift[6:0], sda_s};
        bitcnt <= bitcnt + 4'h1;
      end
      else if (scl_fall && byte_done && state != SMBT_TX)
      begin
        bitcnt   <= 4'h0;
        byte_idx <= (byte_idx == 2'h3) ? 2'h3 : byte_idx + 2'h1;
        if (state == SMBT_RX && byte_idx == 2'h1)
          reg_sel <= shift;
      end
      else if (scl_fall && state == SMBT_ACK && read_phase)
      begin
        tx_byte <= read_mux(reg_sel, power_state_in);
        bitcnt  <= 4'h0;
      end
      else if (scl_fall && state == SMBT_TX)
      begin
        tx_byte <= {tx_byte[6:0], 1'b0};
        bitcnt  <= byte_done ? 4'h0 : bitcnt + 4'h1;
      end
      if (stop_det)
        byte_idx <= 2'h0;
    end
  end

  // sda driven low for ack, or for zero bits of the read byte
  wire drive_ack  = (next_state == SMBT_ACK);
  wire drive_data = (next_state == SMBT_TX) && !tx_byte_bit();

  function automatic logic tx_byte_bit();
    tx_byte_bit = (state == SMBT_ACK) ? read_mux(reg_sel, power_state_in)
                                        [7] : tx_byte[7];
  endfunction

  wire wake_cmd  = cmd_fire && (cmd == `SMBT_CMD_WAKE);
  wire pd_cmd    = cmd_fire && (cmd == `SMBT_CMD_PWRDN);
  wire warm_cmd  = cmd_fire && (cmd == `SMBT_CMD_RST_WARM) && in_s0;
  wire cold_ok   = in_s0 || me_m3_in || graceful_sleep_in;
  wire cold_cmd  = cmd_fire && (cmd == `SMBT_CMD_RST_COLD) && cold_ok;
  wire off_cmd   = cmd_fire && (cmd == `SMBT_CMD_MSG_OFF);
  wire wd_cmd    = cmd_fire && (cmd == `SMBT_CMD_WATCHDOG_RELOAD_COMMAND);
  wire link_cmd  = cmd_fire && (cmd == `SMBT_CMD_LINK_INT) && in_s0;
  logic in_s0_d;
  wire s0_entry  = in_s0 && !in_s0_d;
  // pulse on set in S0, or on S0 re-entry while still pending
  wire link_int  = link_cmd || (s0_entry && link_target_interrupt_status_out);

  // sda_out stays 0; the enable alone pulls the open-drain line low
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sda_out    <= 1'b0;
      sda_oe_out <= 1'b0;
    end
    else
    begin
      sda_out    <= 1'b0;
      sda_oe_out <= drive_ack || drive_data;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      in_s0_d <= 1'b0;
    else
      in_s0_d <= in_s0;
  end

  // one-cycle pulses towards system logic
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wake_out                        <= 1'b0;
      system_management_interrupt_out <= 1'b0;
      power_down_out                  <= 1'b0;
      reset_warm_out                  <= 1'b0;
      reset_cold_out                  <= 1'b0;
      watchdog_reload_command_out     <= 1'b0;
      link_target_interrupt_out       <= 1'b0;
    end
    else
    begin
      wake_out   <= wake_cmd && !system_awake_in;
      system_management_interrupt_out <= wake_cmd && system_awake_in;
      power_down_out              <= pd_cmd;
      reset_warm_out              <= warm_cmd;
      reset_cold_out              <= cold_cmd;
      watchdog_reload_command_out <= wd_cmd;
      // other codes decode to nothing here
      link_target_interrupt_out   <= link_int;
    end
  end

  // messages stay off until the resume-well reset has gone through a cycle
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      health_monitor_msg_en_out <= 1'b1;
    else if (off_cmd)
      health_monitor_msg_en_out <= 1'b0;
    else if (rsm_rise)
      health_monitor_msg_en_out <= 1'b1;
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      bus_wake_status_out <= 1'b0;
    else if (wake_cmd)
      bus_wake_status_out <= 1'b1;
    else if (bus_wake_status_clr_in)
      bus_wake_status_out <= 1'b0;
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      power_button_override_status_out <= 1'b0;
    else if (pd_cmd)
      power_button_override_status_out <= 1'b1;
    else if (power_button_override_status_clr_in)
      power_button_override_status_out <= 1'b0;
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      link_target_interrupt_status_out <= 1'b0;
    else if (link_cmd)
      link_target_interrupt_status_out <= 1'b1;
    else if (link_target_interrupt_status_clr_in)
      link_target_interrupt_status_out <= 1'b0;
  end
endmodule

// ===== sim/smbt_target_chk.sv
// checker on the ports of smbt_target
// assumes one clock domain; bound by the line at the foot
`timescale 1ns/100ps
`include "smbt_defs.svh"
module smbt_target_chk
(
  input wire logic       core_clk_in,
  input wire logic       rst_b_in,
  input wire logic       resume_well_reset_n_in,
  input wire logic       system_awake_in,
  input wire logic [2:0] power_state_in,
  input wire logic       me_m3_in,
  input wire logic       graceful_sleep_in,
  input wire logic       wake_out,
  input wire logic       system_management_interrupt_out,
  input wire logic       power_down_out,
  input wire logic       reset_warm_out,
  input wire logic       reset_cold_out,
  input wire logic       health_monitor_msg_en_out,
  input wire logic       bus_wake_status_out,
  input wire logic       power_button_override_status_out,
  input wire logic       link_target_interrupt_status_out
);
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  AST_WAKE_ASLEEP: assert property (
    wake_out |-> !system_awake_in) else $error("wake while awake");
  AST_SMI_AWAKE: assert property (
    system_management_interrupt_out |-> system_awake_in)
    else $error("interrupt while asleep");
  AST_WAKE_FLAG: assert property (
    wake_out || system_management_interrupt_out
    |-> ##[0:2] bus_wake_status_out) else $error("wake flag not set");
  AST_PDN_FLAG: assert property (
    power_down_out |-> ##[0:2] power_button_override_status_out)
    else $error("override flag not set");
  AST_WARM_S0: assert property (
    reset_warm_out |-> power_state_in == `SMBT_PS_S0)
    else $error("warm reset in sleep");
  AST_COLD_OK: assert property (
    reset_cold_out |-> power_state_in == `SMBT_PS_S0 || me_m3_in
    || graceful_sleep_in) else $error("cold reset refused case");
  AST_LINK_S0: assert property (
    $rose(link_target_interrupt_status_out)
    |-> power_state_in == `SMBT_PS_S0) else $error("link flag in sleep");
  AST_MSG_HOLD: assert property (
    (!health_monitor_msg_en_out && resume_well_reset_n_in) [*8]
    |=> !health_monitor_msg_en_out) else $error("messages back early");
endmodule
bind smbt_target smbt_target_chk u_chk (.*);

// ===== sim/smbt_host_model.sv
// bus initiator model: byte write and byte read frames, open-drain sda
// assumes sda_in is the wire with pull-up; scl stands high between frames
`timescale 1ns/100ps
module smbt_host_model
(
  output logic      scl_out,
  output logic      sda_out,
  input  wire logic sda_in
);
  int lo = 24; // scl low time in ns; raise it for a slow initiator
  logic rd_ok; // last read: three acks seen, data byte left not-acked
  initial
  begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic bitx(input logic b, output logic s);
    #(lo / 2) sda_out = b;
    #(lo - lo / 2) scl_out = 1'b1;
    #12 s = sda_in;
    #12 scl_out = 1'b0;
  endtask
  task automatic start();
    #(lo) sda_out = 1'b1;
    #12 scl_out = 1'b1;
    #12 sda_out = 1'b0;
    #12 scl_out = 1'b0;
  endtask
  task automatic stop();
    #(lo) sda_out = 1'b0;
    #12 scl_out = 1'b1;
    #12 sda_out = 1'b1;
    #24;
  endtask
  // ninth bit always released: ack slot on writes, not-ack on read data
  task automatic xfer(input logic [7:0] d, output logic [7:0] q,
                      output logic r);
    for (int i = 7; i >= 0; i--)
      bitx(d[i], q[i]);
    bitx(1'b1, r);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] c, d,
                    output logic ok);
    logic [7:0] q;
    logic [2:0] r;
    start();
    xfer({a, 1'b0}, q, r[0]);
    xfer(c, q, r[1]);
    xfer(d, q, r[2]);
    stop();
    ok = r == 3'h0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] c,
                    output logic [7:0] v);
    logic [7:0] q;
    logic [3:0] r;
    start();
    xfer({a, 1'b0}, q, r[0]);
    xfer(c, q, r[1]);
    start();
    xfer({a, 1'b1}, q, r[2]);
    xfer(8'hFF, v, r[3]);
    stop();
    rd_ok = r == 4'h8;
  endtask
endmodule

// ===== sim/smbt_target_tb.sv
// bench: commands and status reads through the initiator model
// assumes the design, the model and the checker bind are compiled first
`timescale 1ns/100ps
`include "smbt_defs.svh"
module smbt_target_tb;
  import smbt_pkg::*;
  logic core_clk_in, rst_b_in, resume_well_reset_n_in, scl_in, h_sda, ok;
  logic system_awake_in, me_m3_in, graceful_sleep_in, sda_out, sda_oe_out;
  logic bus_wake_status_clr_in, power_button_override_status_clr_in;
  logic link_target_interrupt_status_clr_in, wake_out, power_down_out;
  logic system_management_interrupt_out, reset_warm_out, reset_cold_out;
  logic watchdog_reload_command_out, health_monitor_msg_en_out;
  logic bus_wake_status_out, power_button_override_status_out;
  logic link_target_interrupt_status_out, link_target_interrupt_out;
  smbt_pstate_t power_state_in;
  logic [6:0]   seen;
  logic [7:0]   q;
  logic [2:0]   ps_tab [4] = '{3'h0, 3'h3, 3'h4, 3'h5};
  logic [7:0]   rsv [4] = '{8'h00, 8'h07, 8'h09, 8'hFF};
  int           err_total = 0;
  int           check_count = 0;
  wire          sda_in = h_sda & !sda_oe_out;
  wire  [6:0]   pl = {wake_out, system_management_interrupt_out,
    power_down_out, reset_warm_out, reset_cold_out,
    watchdog_reload_command_out, link_target_interrupt_out};
  wire  [3:0]   sts = {bus_wake_status_out, power_button_override_status_out,
    link_target_interrupt_status_out, health_monitor_msg_en_out};
  smbt_target dut (.*, .receive_target_address_in(`SMBT_ADDR_RESET));
  smbt_host_model u_host (.scl_out(scl_in), .sda_out(h_sda), .sda_in);
  always @(posedge core_clk_in) seen <= seen | pl;
  initial
  begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end
  task automatic chk(input string n, input logic [7:0] e, g);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // state, awake, engine in M3, graceful sleep entry
  task automatic st(input logic [5:0] v);
    @(posedge core_clk_in);
    {power_state_in, system_awake_in, me_m3_in, graceful_sleep_in} <= v;
  endtask
  task automatic clr(input logic v);
    @(posedge core_clk_in);
    {bus_wake_status_clr_in, power_button_override_status_clr_in,
     link_target_interrupt_status_clr_in} <= {3{v}};
  endtask
  task automatic cmd(input logic [6:0] a, input logic [7:0] c,
                     input logic [6:0] e, input logic [3:0] s);
    @(negedge core_clk_in) seen = 7'h00;
    u_host.wr(a, `SMBT_REG_CMD, c, ok);
    repeat (20) @(posedge core_clk_in);
    @(negedge core_clk_in);
    chk("pulses", {1'b0, e}, {1'b0, seen});
    chk("ack", {7'h00, a == 7'h44}, {7'h00, ok});
    chk("status", {4'h0, s}, {4'h0, sts});
  endtask
  initial
  begin
    rst_b_in = 1'b0;
    resume_well_reset_n_in = 1'b1;
    {power_state_in, system_awake_in, me_m3_in, graceful_sleep_in} = 6'h28;
    {bus_wake_status_clr_in, power_button_override_status_clr_in,
     link_target_interrupt_status_clr_in} = 3'h0;
    repeat (4) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    chk("status", 8'h01, {4'h0, sts});
    u_host.rd(7'h44, `SMBT_REG_CAP, q);
    chk("cap", 8'h00, q);
    chk("rdack", 8'h01, {7'h00, u_host.rd_ok});
    foreach (ps_tab[i])
    begin
      st({ps_tab[i], 3'h0});
      u_host.rd(7'h44, `SMBT_REG_PSTATE, q);
      chk("pstate", {5'h00, ps_tab[i]}, q);
      chk("rdack", 8'h01, {7'h00, u_host.rd_ok});
    end
    cmd(7'h44, 8'h01, 7'h40, 4'h9);
    st(6'h04);
    cmd(7'h44, 8'h01, 7'h20, 4'h9);
    clr(1'b1);
    clr(1'b0);
    cmd(7'h44, 8'h02, 7'h10, 4'h5);
    cmd(7'h44, 8'h03, 7'h08, 4'h5);
    cmd(7'h44, 8'h06, 7'h02, 4'h5);
    cmd(7'h44, 8'h08, 7'h01, 4'h7);
    st(6'h18);
    @(negedge core_clk_in) seen = 7'h00;
    st(6'h04);
    repeat (10) @(posedge core_clk_in);
    chk("reentry", 8'h01, {1'b0, seen});
    clr(1'b1);
    clr(1'b0);
    st(6'h18);
    cmd(7'h44, 8'h08, 7'h00, 4'h1);
    cmd(7'h44, 8'h03, 7'h00, 4'h1);
    cmd(7'h44, 8'h04, 7'h00, 4'h1);
    st(6'h1A);
    cmd(7'h44, 8'h04, 7'h04, 4'h1);
    st(6'h21);
    cmd(7'h44, 8'h04, 7'h04, 4'h1);
    foreach (rsv[i])
      cmd(7'h44, rsv[i], 7'h00, 4'h1);
    cmd(7'h45, 8'h01, 7'h00, 4'h1);
    u_host.lo = 60;
    cmd(7'h44, 8'h05, 7'h00, 4'h0);
    repeat (20) @(posedge core_clk_in);
    resume_well_reset_n_in <= 1'b0;
    repeat (8) @(posedge core_clk_in);
    resume_well_reset_n_in <= 1'b1;
    repeat (8) @(posedge core_clk_in);
    chk("status", 8'h01, {4'h0, sts});
    print_verdict();
  end
  initial
  begin
    #300000;
    err_total++;
    print_verdict();
  end
endmodule
